//--- lcd_pkg.sv
package lcd_pkg;
    // register map
    localparam logic [15:0] ADDR_DISPLAY_MODE  = 16'hFFB0;
    localparam logic [15:0] ADDR_CLOCK_CONTROL = 16'hFFB2;
    localparam logic [15:0] ADDR_MEM_BASE      = 16'hFA00;
    localparam int          SEG_COUNT          = 15;
    localparam int          COM_COUNT          = 4;
    localparam logic [4:0]  MEM_DEPTH          = 5'h0F;

    // reset values and bits that hold storage
    localparam logic [7:0] MODE_RESET  = 8'h00;
    localparam logic [7:0] CLOCK_RESET = 8'h00;
    localparam logic [7:0] MODE_MASK   = 8'hD1;
    localparam logic [7:0] CLOCK_MASK  = 8'h0F;
    localparam logic [3:0] MEM_RESET   = 4'h0;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // field positions
    localparam int DISPLAY_ENABLE_BIT     = 7;
    localparam int AMPLIFY_ENABLE_BIT     = 6;
    localparam int PIN_OUTPUT_CONTROL_BIT = 4;
    localparam int SLOT_COUNT_SELECT      = 0;
    localparam int SOURCE_CLOCK_SEL_LO    = 2;
    localparam int DIVIDER_SEL_LO         = 0;
    localparam int MEM_DATA_BITS          = 4;

    // clocking: main clock /2^(4+sel), lcd clock source /2^(6+sel)
    localparam logic [1:0] SRC_SUBSYSTEM      = 2'h0;
    localparam int         MAIN_DIV_BASE_LOG2 = 4;
    localparam int         LCD_DIV_BASE_LOG2  = 6;
    localparam logic [6:0] PRESC_RESET        = 7'h00;
    localparam logic [8:0] DIV_RESET          = 9'h000;

    // time slots
    localparam logic [1:0] LAST_SLOT_FOUR  = 2'h3;
    localparam logic [1:0] LAST_SLOT_THREE = 2'h2;
    localparam logic [1:0] SLOT_RESET      = 2'h0;

    // drive levels at one-third bias, as fractions of the lcd voltage
    typedef logic [1:0] level_t;
    localparam level_t LVL_GND        = 2'h0;
    localparam level_t LVL_THIRD      = 2'h1;
    localparam level_t LVL_TWO_THIRDS = 2'h2;
    localparam level_t LVL_FULL       = 2'h3;

    typedef struct packed {
        logic        wr;
        logic        bit_wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [2:0]  bit_sel;
        logic        bit_val;
    } cpu_req_s;

    typedef struct packed {
        level_t [SEG_COUNT-1:0] seg;
        level_t [COM_COUNT-1:0] com;
        logic                   amp_en;
    } lcd_pins_s;
endpackage

//--- lcd_segment_common_driver.sv
`timescale 1ns/1ps
module lcd_segment_common_driver (
    input  wire logic                sys_clk,
    input  wire logic                rst_n,
    input  wire lcd_pkg::cpu_req_s   cpu_req,
    input  wire logic                sub_osc_clk,
    output logic [7:0]               cpu_rdata,
    output lcd_pkg::lcd_pins_s       lcd_pins
);

    typedef struct packed {
        logic [7:0]                              mode;
        logic [7:0]                              clk_ctl;
        logic [lcd_pkg::SEG_COUNT-1:0][3:0]      mem;
        logic [1:0]                              sub_sync;
        logic                                    sub_prev;
        logic [6:0]                              presc;
        logic [8:0]                              div;
        logic [1:0]                              slot;
        logic                                    pol;
        lcd_pkg::lcd_pins_s                      pins;
        logic [7:0]                              rdata;
    } state_s;

    state_s       state_reg;
    state_s       state_next;
    logic         src_tick;
    logic         lcd_tick;
    logic [1:0]   last_slot;
    logic [1:0]   src_sel;
    logic [1:0]   div_sel;
    logic         out_ctrl;
    logic         disp_en;
    logic [3:0]   mem_idx;

    // true when the low n bits of v are all ones
    function automatic logic low_ones(input logic [8:0] v, input int n);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 9; i++) begin
            if (i < n && !v[i]) begin
                r = 1'b0;
            end
        end
        return r;
    endfunction

    // display memory decode, shared by reads and writes
    function automatic logic mem_hit(input logic [15:0] a);
        logic [15:0] off;
        off = a - lcd_pkg::ADDR_MEM_BASE;
        return (a >= lcd_pkg::ADDR_MEM_BASE) &&
               (off < {11'h000, lcd_pkg::MEM_DEPTH});
    endfunction

    // one-third bias levels; commons swing full/third, segments ground/two
    function automatic lcd_pkg::level_t drive_level(input logic sel,
                                                    input logic is_com,
                                                    input logic pol);
        lcd_pkg::level_t base;
        if (is_com) begin
            base = sel ? lcd_pkg::LVL_FULL : lcd_pkg::LVL_THIRD;
        end else begin
            base = sel ? lcd_pkg::LVL_GND : lcd_pkg::LVL_TWO_THIRDS;
        end
        // inverting the code mirrors the level about half supply
        return pol ? ~base : base;
    endfunction

    assign mem_idx = cpu_req.addr[3:0] - lcd_pkg::ADDR_MEM_BASE[3:0];

    // next-state logic: register bus, clock chain, slot scan, pin drive
    always_comb begin
        state_next = state_reg;
        src_sel    = state_reg.clk_ctl[lcd_pkg::SOURCE_CLOCK_SEL_LO +: 2];
        div_sel    = state_reg.clk_ctl[lcd_pkg::DIVIDER_SEL_LO +: 2];
        out_ctrl   = state_reg.mode[lcd_pkg::PIN_OUTPUT_CONTROL_BIT];
        disp_en    = state_reg.mode[lcd_pkg::DISPLAY_ENABLE_BIT];
        last_slot  = state_reg.mode[lcd_pkg::SLOT_COUNT_SELECT] ?
                     lcd_pkg::LAST_SLOT_THREE :
                     lcd_pkg::LAST_SLOT_FOUR;

        // byte and single-bit writes; reserved bits never store
        if (cpu_req.addr == lcd_pkg::ADDR_DISPLAY_MODE) begin
            if (cpu_req.wr) begin
                state_next.mode = cpu_req.wdata & lcd_pkg::MODE_MASK;
            end else if (cpu_req.bit_wr) begin
                state_next.mode[cpu_req.bit_sel] = cpu_req.bit_val &
                    lcd_pkg::MODE_MASK[cpu_req.bit_sel];
            end
        end
        if (cpu_req.addr == lcd_pkg::ADDR_CLOCK_CONTROL) begin
            if (cpu_req.wr) begin
                state_next.clk_ctl = cpu_req.wdata & lcd_pkg::CLOCK_MASK;
            end else if (cpu_req.bit_wr) begin
                state_next.clk_ctl[cpu_req.bit_sel] = cpu_req.bit_val &
                    lcd_pkg::CLOCK_MASK[cpu_req.bit_sel];
            end
        end
        // upper nibble of each memory byte has no storage
        if (mem_hit(cpu_req.addr)) begin
            if (cpu_req.wr) begin
                state_next.mem[mem_idx] = cpu_req.wdata[3:0];
            end else if (cpu_req.bit_wr && !cpu_req.bit_sel[2]) begin
                state_next.mem[mem_idx][cpu_req.bit_sel[1:0]] =
                    cpu_req.bit_val;
            end
        end

        // registered read data; unmapped addresses read zero
        if (cpu_req.rd) begin
            if (cpu_req.addr == lcd_pkg::ADDR_DISPLAY_MODE) begin
                state_next.rdata = state_reg.mode;
            end else if (cpu_req.addr == lcd_pkg::ADDR_CLOCK_CONTROL) begin
                state_next.rdata = state_reg.clk_ctl;
            end else if (mem_hit(cpu_req.addr)) begin
                state_next.rdata = {4'h0, state_reg.mem[mem_idx]};
            end else begin
                state_next.rdata = 8'h00;
            end
        end

        // subsystem oscillator pin: two-flop synchroniser, then edge
        state_next.sub_sync = {state_reg.sub_sync[0], sub_osc_clk};
        state_next.sub_prev = state_reg.sub_sync[1];

        // source clock: the subsystem path needs no main-clock divider
        state_next.presc = state_reg.presc + 7'h01;
        if (src_sel == lcd_pkg::SRC_SUBSYSTEM) begin
            src_tick = state_reg.sub_sync[1] & ~state_reg.sub_prev;
        end else begin
            src_tick = low_ones({2'h0, state_reg.presc},
                lcd_pkg::MAIN_DIV_BASE_LOG2 + int'(src_sel));
        end

        // lcd clock: source divided by 2^(6+sel)
        lcd_tick = src_tick && low_ones(state_reg.div,
            lcd_pkg::LCD_DIV_BASE_LOG2 + int'(div_sel));
        if (src_tick) begin
            state_next.div = state_reg.div + 9'h001;
        end

        // one slot per lcd clock; frame ends after the last slot
        if (lcd_tick) begin
            if (state_reg.slot >= last_slot) begin
                state_next.slot = lcd_pkg::SLOT_RESET;
                state_next.pol  = ~state_reg.pol;
            end else begin
                state_next.slot = state_reg.slot + 2'h1;
            end
        end

        state_next.pins.amp_en = state_reg.mode[lcd_pkg::AMPLIFY_ENABLE_BIT];

        // commons: unused line held at ground so it may be left open
        for (int c = 0; c < lcd_pkg::COM_COUNT; c++) begin
            if (!out_ctrl || (2'(c) > last_slot)) begin
                state_next.pins.com[c] = lcd_pkg::LVL_GND;
            end else begin
                state_next.pins.com[c] = drive_level(
                    state_reg.slot == 2'(c), 1'b1, state_reg.pol);
            end
        end

        // segments: data bit of the active slot picks select level
        for (int g = 0; g < lcd_pkg::SEG_COUNT; g++) begin
            if (!out_ctrl) begin
                state_next.pins.seg[g] = lcd_pkg::LVL_GND;
            end else begin
                state_next.pins.seg[g] = drive_level(
                    disp_en && state_reg.mem[g][state_reg.slot],
                    1'b0, state_reg.pol);
            end
        end
    end

    // whole state in one register; reset brings display off, pins ground
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg          <= '0;
            state_reg.mode     <= lcd_pkg::MODE_RESET;
            state_reg.clk_ctl  <= lcd_pkg::CLOCK_RESET;
            state_reg.presc    <= lcd_pkg::PRESC_RESET;
            state_reg.div      <= lcd_pkg::DIV_RESET;
            state_reg.slot     <= lcd_pkg::SLOT_RESET;
            state_reg.rdata    <= lcd_pkg::RDATA_RESET;
            for (int g = 0; g < lcd_pkg::SEG_COUNT; g++) begin
                state_reg.mem[g] <= lcd_pkg::MEM_RESET;
            end
        end else begin
            state_reg <= state_next;
        end
    end

    assign cpu_rdata = state_reg.rdata;
    assign lcd_pins  = state_reg.pins;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence mode_byte_write;
        cpu_req.wr && cpu_req.addr == lcd_pkg::ADDR_DISPLAY_MODE;
    endsequence

    sequence mode_bit_write;
        !cpu_req.wr && cpu_req.bit_wr &&
        cpu_req.addr == lcd_pkg::ADDR_DISPLAY_MODE;
    endsequence

    sequence frame_end;
        lcd_tick && state_reg.slot >= last_slot;
    endsequence

    AST_GROUND_WHEN_OUTPUTS_OFF: assert property (
        !out_ctrl |=> (state_reg.pins.seg == '0 && state_reg.pins.com == '0))
        else $error("pins not at ground with output control clear");

    AST_SEG_DESELECT_WHEN_DISPLAY_OFF: assert property (
        (out_ctrl && !disp_en) |=>
        (state_reg.pins.seg[0] == lcd_pkg::LVL_TWO_THIRDS ||
         state_reg.pins.seg[0] == lcd_pkg::LVL_THIRD))
        else $error("segment not at deselect level with display off");

    AST_MODE_BYTE_WRITE: assert property (
        mode_byte_write |=>
        state_reg.mode == ($past(cpu_req.wdata) & lcd_pkg::MODE_MASK))
        else $error("mode byte write not stored");

    AST_MODE_BIT_WRITE: assert property (
        mode_bit_write ##0 (cpu_req.bit_sel == 3'h7) |=>
        (state_reg.mode[7] == $past(cpu_req.bit_val) &&
         state_reg.mode[6:0] == $past(state_reg.mode[6:0])))
        else $error("mode bit write touched other bits");

    AST_CLOCK_BYTE_WRITE: assert property (
        (cpu_req.wr && cpu_req.addr == lcd_pkg::ADDR_CLOCK_CONTROL) |=>
        state_reg.clk_ctl == ($past(cpu_req.wdata) & lcd_pkg::CLOCK_MASK))
        else $error("clock control write not stored");

    AST_SLOT_WRAP: assert property (
        frame_end |=> state_reg.slot == lcd_pkg::SLOT_RESET)
        else $error("slot did not wrap at frame end");

    AST_POLARITY_FLIP: assert property (
        frame_end |=> state_reg.pol != $past(state_reg.pol))
        else $error("polarity did not flip at frame end");

    AST_COMMON3_IDLE_THREE_SLOT: assert property (
        state_reg.mode[lcd_pkg::SLOT_COUNT_SELECT] |=>
        state_reg.pins.com[3] == lcd_pkg::LVL_GND)
        else $error("common three driven in three-slot mode");

    // a source change on the tick edge may legally tick from the new source
    AST_MAIN_SOURCE_TICK: assert property (
        (src_sel == 2'h1 && state_reg.presc[4:0] == 5'h1F) |-> src_tick ##1
        (src_sel != 2'h1 || !src_tick))
        else $error("main clock /32 source tick wrong");

    AST_AMP_FOLLOWS_BIT: assert property (
        state_reg.mode[lcd_pkg::AMPLIFY_ENABLE_BIT] ##1
        state_reg.mode[lcd_pkg::AMPLIFY_ENABLE_BIT] |-> state_reg.pins.amp_en)
        else $error("amplifier enable not on pin");

    AST_COMMON_SELECTED: assert property (
        (out_ctrl && !state_reg.pol && state_reg.slot == 2'h0) |=>
        state_reg.pins.com[0] == lcd_pkg::LVL_FULL)
        else $error("common zero not selected in slot zero");

    AST_SEG_SELECTED: assert property (
        (out_ctrl && disp_en && !state_reg.pol &&
         state_reg.mem[0][state_reg.slot]) |=>
        state_reg.pins.seg[0] == lcd_pkg::LVL_GND)
        else $error("segment zero not at select level");

    AST_SLOT_ADVANCE: assert property (
        (lcd_tick && state_reg.slot < last_slot) |=>
        state_reg.slot == $past(state_reg.slot) + 2'h1)
        else $error("slot did not advance on lcd clock");

    AST_MEM_READ: assert property (
        (cpu_req.rd && mem_hit(cpu_req.addr)) |=>
        cpu_rdata == {4'h0, $past(state_reg.mem[mem_idx])})
        else $error("display memory read data wrong");

endmodule

//--- lcd_panel_model.sv
`timescale 1ns/1ps
// glass model: a pixel lights when its common and segment sit at opposite
// rails, which happens for a select pairing at one-third bias and for a full-level segment against the grounded unused common
module lcd_panel_model (
    input  wire logic               sys_clk,
    input  wire logic               clear,
    input  wire lcd_pkg::lcd_pins_s lcd_pins,
    output logic [59:0]             lit
);
    // sticky per pixel so one look after a frame shows the whole pattern
    always_ff @(posedge sys_clk) begin
        for (int g = 0; g < lcd_pkg::SEG_COUNT; g++) begin
            for (int c = 0; c < lcd_pkg::COM_COUNT; c++) begin
                if (clear)
                    lit[g*4+c] <= 1'b0;
                else if ({lcd_pins.seg[g], lcd_pins.com[c]} == 4'h3 ||
                         {lcd_pins.seg[g], lcd_pins.com[c]} == 4'hC)
                    lit[g*4+c] <= 1'b1;
            end
        end
    end
endmodule

//--- lcd_segment_common_driver_test.sv
`timescale 1ns/1ps
`define CHECK(NAME, EXP, GOT) begin compares++; if ((GOT) !== (EXP)) begin \
    num_errors++; $display("[FAIL] %s expected %0h seen %0h", NAME, EXP, \
    GOT); end end
module lcd_segment_common_driver_test;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [7:0]  exp;
    } reg_row_s;
    typedef struct {
        logic [7:0] clk;
        logic       slot3;
        int         period;
    } clk_row_s;
    logic               sys_clk;
    logic               rst_n;
    logic               sub_osc_clk;
    logic               clear;
    lcd_pkg::cpu_req_s  cpu_req;
    logic [7:0]         cpu_rdata;
    lcd_pkg::lcd_pins_s lcd_pins;
    logic [59:0]        lit;
    int                 num_errors;
    int                 compares;
    logic [7:0]         rd;
    logic [3:0]         mem [15];
    reg_row_s reg_rows [7] = '{'{16'hFFB2, 8'hFF, 8'h0F},
        '{16'hFFB2, 8'h00, 8'h00}, '{16'hFFB0, 8'h2F, 8'h01},
        '{16'hFFB0, 8'h00, 8'h00}, '{16'hFA0E, 8'hA5, 8'h05},
        '{16'hFA0F, 8'hFF, 8'h00}, '{16'hFFB1, 8'hFF, 8'h00}};
    // sub osc runs at 20 sys clocks a period to keep frames short; main
    // rows use the programmed dividers, only the oscillator row is time-compressed
    clk_row_s clk_rows [3] = '{'{8'h04, 1'b0, 2048},
        '{8'h08, 1'b1, 4096}, '{8'h01, 1'b0, 2560}};

    lcd_segment_common_driver i_lcd_segment_common_driver (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .cpu_req     (cpu_req),
        .sub_osc_clk (sub_osc_clk),
        .cpu_rdata   (cpu_rdata),
        .lcd_pins    (lcd_pins)
    );
    lcd_panel_model i_lcd_panel_model (
        .sys_clk  (sys_clk),
        .clear    (clear),
        .lcd_pins (lcd_pins),
        .lit      (lit)
    );

    // both clocks; the oscillator edges land on sys_clk falling edges
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        sub_osc_clk = 1'b0;
        forever #100 sub_osc_clk = ~sub_osc_clk;
    end

    task automatic req(input lcd_pkg::cpu_req_s r);
        @(posedge sys_clk);
        #1 cpu_req = r;
        @(posedge sys_clk);
        #1 cpu_req = '0;
    endtask
    task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
        req('{wr: 1'b1, addr: a, wdata: d, default: '0});
    endtask
    task automatic bit_wr(input logic [2:0] n, input logic v);
        req('{bit_wr: 1'b1, addr: 16'hFFB0, bit_sel: n, bit_val: v,
              default: '0});
    endtask
    task automatic rd_byte(input logic [15:0] a);
        req('{rd: 1'b1, addr: a, default: '0});
        @(posedge sys_clk);
        #1 rd = cpu_rdata;
    endtask
    function automatic lcd_pkg::level_t exp_seg(input logic on,
                                                input logic pol);
        if (on)
            return pol ? lcd_pkg::LVL_FULL : lcd_pkg::LVL_GND;
        return pol ? lcd_pkg::LVL_THIRD : lcd_pkg::LVL_TWO_THIRDS;
    endfunction

    // follow six slot boundaries; the first skips the gap, slot and polarity checks
    task automatic watch(input logic slot3, input int period);
        int gap = 0;
        int n = 0;
        int s = 0;
        int ps = 0;
        logic pol = 1'b0;
        logic ppol = 1'b0;
        lcd_pkg::level_t [3:0] prev = lcd_pins.com;
        while (n < 6 && gap < 3 * period) begin
            @(posedge sys_clk);
            #1 gap++;
            if (lcd_pins.com !== prev) begin
                for (int c = 0; c < 4 - slot3; c++) begin
                    if (lcd_pins.com[c] inside {lcd_pkg::LVL_FULL,
                                                lcd_pkg::LVL_GND}) begin
                        s = c;
                        pol = (lcd_pins.com[c] === lcd_pkg::LVL_GND);
                    end
                end
                if (n > 0) begin
                    `CHECK("slot gap", period, gap)
                    `CHECK("slot", (ps + 1) % (4 - slot3), s)
                    `CHECK("polarity", ppol ^ (s == 0), pol)
                end
                if (slot3)
                    `CHECK("common_line_3", lcd_pkg::LVL_GND, lcd_pins.com[3])
                for (int g = 0; g < 15; g++)
                    `CHECK("seg", exp_seg(mem[g][s], pol), lcd_pins.seg[g])
                ps = s;
                ppol = pol;
                prev = lcd_pins.com;
                gap = 0;
                n++;
            end
        end
        `CHECK("boundaries", 6, n)
    endtask

    task automatic tally_and_finish;
        if (num_errors == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // the three clock rows take about 52k cycles together; margin kept
    initial begin
        repeat (90000) @(posedge sys_clk);
        num_errors++;
        tally_and_finish;
    end

    // main sequence: reset, register rows, clock rows, shutdown, reset
    initial begin
        num_errors = 0;
        compares = 0;
        rst_n = 1'b0;
        clear = 1'b0;
        cpu_req = '0;
        repeat (4) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        `CHECK("pins", '0, lcd_pins)
        rd_byte(16'hFFB0);
        `CHECK("mode", 8'h00, rd)
        rd_byte(16'hFFB2);
        `CHECK("clock", 8'h00, rd)
        foreach (reg_rows[i]) begin
            wr_byte(reg_rows[i].addr, reg_rows[i].wdata);
            rd_byte(reg_rows[i].addr);
            `CHECK("register", reg_rows[i].exp, rd)
        end
        for (int g = 0; g < 15; g++) begin
            mem[g] = 4'(g * 7 + 1);
            wr_byte(lcd_pkg::ADDR_MEM_BASE + 16'(g), {4'h0, mem[g]});
        end
        foreach (clk_rows[i]) begin
            bit_wr(3'h7, 1'b0);
            bit_wr(3'h4, 1'b0);
            bit_wr(3'h6, 1'b0);
            wr_byte(16'hFFB2, clk_rows[i].clk);
            bit_wr(3'h0, clk_rows[i].slot3);
            bit_wr(3'h6, 1'b1);
            // amplifier settling wait, shortened for simulation
            repeat (20) @(posedge sys_clk);
            bit_wr(3'h4, 1'b1);
            bit_wr(3'h7, 1'b1);
            rd_byte(16'hFFB0);
            `CHECK("mode", {7'h68, clk_rows[i].slot3}, rd)
            `CHECK("amp", 1'b1, lcd_pins.amp_en)
            @(posedge sys_clk);
            #1 clear = 1'b1;
            @(posedge sys_clk);
            #1 clear = 1'b0;
            watch(clk_rows[i].slot3, clk_rows[i].period);
            for (int g = 0; g < 15; g++)
                for (int c = 0; c < 4 - clk_rows[i].slot3; c++)
                    `CHECK("pixel", mem[g][c], lit[g*4+c])
        end
        bit_wr(3'h7, 1'b0);
        repeat (3) @(posedge sys_clk);
        #1;
        for (int g = 0; g < 15; g++)
            `CHECK("off", 1'b1, lcd_pins.seg[g] inside {2'h1, 2'h2})
        bit_wr(3'h4, 1'b0);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHECK("ground", '0, {lcd_pins.seg, lcd_pins.com})
        bit_wr(3'h6, 1'b0);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHECK("amp", 1'b0, lcd_pins.amp_en)
        // second reset with the clock register loaded and amplifier on
        wr_byte(16'hFFB2, 8'h05);
        bit_wr(3'h6, 1'b1);
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        `CHECK("pins", '0, lcd_pins)
        rst_n = 1'b1;
        rd_byte(16'hFFB0);
        `CHECK("mode", 8'h00, rd)
        rd_byte(16'hFFB2);
        `CHECK("clock", 8'h00, rd)
        tally_and_finish;
    end
endmodule
